// ===== logic/fpxu_pkg.sv
// constants and carrier types of the floating exception and operand unit
// assumes one 40 MHz clock and an asynchronous active-low reset from the processor
package fpxu_pkg;

    // instruction layout
    localparam logic [3:0] FPXU_MAJOR_OPCODE   = 4'hf;
    localparam int         FPXU_OPC_HI         = 15;
    localparam int         FPXU_OPC_LO         = 12;
    localparam int         FPXU_SUBOP_HI       = 11;
    localparam int         FPXU_SUBOP_LO       = 8;
    localparam int         FPXU_ACC_HI         = 7;
    localparam int         FPXU_ACC_LO         = 6;
    localparam int         FPXU_MODE_HI        = 5;
    localparam int         FPXU_MODE_LO        = 3;
    localparam int         FPXU_REG_HI         = 2;
    localparam int         FPXU_REG_LO         = 0;

    // addressing modes
    localparam logic [2:0] FPXU_MODE_ACC       = 3'h0;
    localparam logic [2:0] FPXU_MODE_AUTOINC   = 3'h2;
    localparam logic [2:0] FPXU_MODE_AUTOINCD  = 3'h3;
    localparam logic [2:0] FPXU_MODE_AUTODEC   = 3'h4;
    localparam logic [2:0] FPXU_MODE_AUTODECD  = 3'h5;
    localparam logic [2:0] FPXU_ACC_LAST_OK    = 3'h5;

    // address steps: 4 single, 10 octal double
    localparam logic [3:0] FPXU_STEP_SINGLE    = 4'h4;
    localparam logic [3:0] FPXU_STEP_DOUBLE    = 4'h8;

    // shared trap vector, 244 octal
    localparam logic [7:0] FPXU_TRAP_VECTOR    = 8'ha4;

    // exception cause codes
    localparam logic [3:0] FPXU_CODE_NONE      = 4'h0;
    localparam logic [3:0] FPXU_CODE_OPCODE    = 4'h2;
    localparam logic [3:0] FPXU_CODE_DIVZERO   = 4'h4;
    localparam logic [3:0] FPXU_CODE_CONVERT   = 4'h6;
    localparam logic [3:0] FPXU_CODE_OVERFLOW  = 4'h8;
    localparam logic [3:0] FPXU_CODE_UNDERFLOW = 4'ha;
    localparam logic [3:0] FPXU_CODE_UNDEFVAR  = 4'hc;

    // number format
    localparam int         FPXU_EXP_W          = 8;
    localparam int         FPXU_WEXP_W         = 10;
    localparam int         FPXU_FRAC_W         = 56;
    localparam int         FPXU_SFRAC_W        = 24;
    localparam int         FPXU_GUARD_W        = 2;
    localparam int         FPXU_XFRAC_W        = FPXU_FRAC_W + FPXU_GUARD_W;
    localparam logic [FPXU_WEXP_W-1:0] FPXU_EXP_MAX = 10'h0ff;
    localparam logic [FPXU_WEXP_W-1:0] FPXU_EXP_ONE = 10'h001;

    typedef struct packed {
        logic globalIrqDisable;
        logic undefVarIrqEnable;
        logic underflowIrqEnable;
        logic overflowIrqEnable;
        logic convIrqEnable;
        logic doublePrecisionSel;
        logic longIntegerSel;
        logic chopSel;
    } fpxu_ctrl_s;

    typedef struct packed {
        logic        valid;
        logic [15:0] word;
        logic [15:0] addr;
    } fpxu_instr_s;

    typedef struct packed {
        logic                          isDivide;
        logic                          convFail;
        logic                          srcSign;
        logic [FPXU_EXP_W-1:0]         srcExp;
        logic                          dstSign;
        logic [FPXU_EXP_W-1:0]         dstExp;
        logic                          resSign;
        logic [FPXU_WEXP_W-1:0]        resExp;
        logic [FPXU_XFRAC_W-1:0]       resFrac;
    } fpxu_arith_s;

    typedef struct packed {
        logic       isFloat;
        logic [2:0] mode;
        logic [2:0] gpr;
        logic [2:0] accSelect;
        logic       operandIsAcc;
        logic [3:0] stepSize;
        logic       stepUp;
        logic       stepDown;
        logic       intWidth32;
    } fpxu_addr_s;

    typedef struct packed {
        logic                    valid;
        logic                    sign;
        logic [FPXU_EXP_W-1:0]   exp;
        logic [FPXU_FRAC_W-1:0]  frac;
        logic                    zero;
        logic                    overflowFlag;
        logic                    underflowFlag;
    } fpxu_result_s;

    typedef struct packed {
        logic [3:0]   causeCode;
        logic [15:0]  instrAddr;
        logic         errorFlag;
        logic         irqReq;
        logic [7:0]   trapVector;
        fpxu_addr_s   addr;
        fpxu_result_s result;
        logic [15:0]  memWordAddr;
    } fpxu_state_s;

endpackage

// ===== logic/fpxu_exception_unit.sv
// exception capture, operand addressing and result rounding of the floating unit
// assumes the processor presents one instruction with its operand and result data per cycle
`timescale 1ns/1ps
`default_nettype none

module fpxu_exception_unit
    import fpxu_pkg::*;
(
    // clock and reset
    input  wire logic                       ref_clk,
    input  wire logic                       resetn,
    // status word controls
    input  wire fpxu_pkg::fpxu_ctrl_s       ctrl,
    // instruction under execution
    input  wire fpxu_pkg::fpxu_instr_s      instr,
    input  wire logic                       accFieldUsed,
    // operands and raw result
    input  wire fpxu_pkg::fpxu_arith_s      arith,
    // memory word placement
    input  wire logic [15:0]                memBase,
    input  wire logic [1:0]                 memWordIdx,
    // exception registers, read only
    output logic [3:0]                      exception_cause_code,
    output logic [15:0]                     exception_instr_addr,
    output logic                            error_flag,
    // trap request
    output logic                            irqReq,
    output logic [7:0]                      trapVector,
    // decoded addressing
    output fpxu_pkg::fpxu_addr_s            addrInfo,
    output logic [15:0]                     memWordAddr,
    // final result
    output fpxu_pkg::fpxu_result_s          result
);
    import fpxu_pkg::*;

    fpxu_state_s state_reg;
    fpxu_state_s state_next;

    // decode fields
    logic [3:0]  majorOpcode;
    logic [3:0]  float_subopcode;
    logic [1:0]  accumulator_select;
    logic [2:0]  specMode;
    logic [2:0]  specReg;
    logic        isFloat;
    logic        badAcc;

    // exception detection
    logic        undefVar;
    logic        divZero;
    logic        expOverflow;
    logic        expUnderflow;
    logic        capture;
    logic [3:0]  code;

    // rounding path
    logic [FPXU_XFRAC_W-1:0] lsbMask;
    logic [FPXU_XFRAC_W-1:0] keepMask;
    logic [FPXU_XFRAC_W-1:0] chopped;
    logic                    roundBit;
    logic [FPXU_XFRAC_W:0]   rounded;
    logic [FPXU_XFRAC_W-1:0] normFrac;
    logic [FPXU_WEXP_W-1:0]  normExp;
    logic                    operandZero;

    always_comb
    begin
        state_next = state_reg;

        majorOpcode        = instr.word[FPXU_OPC_HI:FPXU_OPC_LO];
        float_subopcode    = instr.word[FPXU_SUBOP_HI:FPXU_SUBOP_LO];
        accumulator_select = instr.word[FPXU_ACC_HI:FPXU_ACC_LO];
        specMode           = instr.word[FPXU_MODE_HI:FPXU_MODE_LO];
        specReg            = instr.word[FPXU_REG_HI:FPXU_REG_LO];
        isFloat            = instr.valid && (majorOpcode == FPXU_MAJOR_OPCODE);

        // accumulators 6 and 7 are illegal through mode 0
        badAcc = isFloat && (specMode == FPXU_MODE_ACC)
                 && (specReg > FPXU_ACC_LAST_OK);

        // minus zero operand while undefined-variable trap is on
        undefVar = isFloat && ctrl.undefVarIrqEnable
                   && ((arith.srcSign && (arith.srcExp == '0))
                       || (arith.dstSign && (arith.dstExp == '0)));

        // divisor is the source operand; a zero dividend is not an error
        divZero = isFloat && arith.isDivide && (arith.srcExp == '0);
        operandZero = (arith.srcExp == '0) || (arith.dstExp == '0);

        // two guard bits below the double lsb; the single lsb sits at bit 34
        lsbMask = ctrl.doublePrecisionSel
                  ? FPXU_XFRAC_W'(1) << FPXU_GUARD_W
                  : FPXU_XFRAC_W'(1) << (FPXU_XFRAC_W - FPXU_SFRAC_W);
        keepMask = ~(lsbMask - FPXU_XFRAC_W'(1));
        chopped  = arith.resFrac & keepMask;
        roundBit = |(arith.resFrac & (lsbMask >> 1));
        if (!ctrl.chopSel && roundBit)
        begin
            rounded = {1'b0, chopped} + {1'b0, lsbMask};
        end
        else
        begin
            rounded = {1'b0, chopped};
        end

        // renormalize on carry out of the rounding add
        if (rounded[FPXU_XFRAC_W])
        begin
            normFrac = rounded[FPXU_XFRAC_W:1] & keepMask;
            normExp  = arith.resExp + FPXU_EXP_ONE;
        end
        else
        begin
            normFrac = rounded[FPXU_XFRAC_W-1:0];
            normExp  = arith.resExp;
        end

        // exponent must fit eight bits
        expOverflow  = isFloat && !operandZero && ($signed(normExp) > $signed(FPXU_EXP_MAX));
        expUnderflow = isFloat && !operandZero && ($signed(normExp) < $signed(FPXU_EXP_ONE));

        // one cause per instruction, most severe first
        code    = FPXU_CODE_NONE;
        capture = 1'b0;
        if (badAcc)
        begin
            code    = FPXU_CODE_OPCODE;
            capture = 1'b1;
        end
        else if (undefVar)
        begin
            code    = FPXU_CODE_UNDEFVAR;
            capture = 1'b1;
        end
        else if (divZero)
        begin
            code    = FPXU_CODE_DIVZERO;
            capture = 1'b1;
        end
        else if (isFloat && arith.convFail)
        begin
            code    = FPXU_CODE_CONVERT;
            capture = ctrl.convIrqEnable;
        end
        else if (expOverflow)
        begin
            code    = FPXU_CODE_OVERFLOW;
            capture = ctrl.overflowIrqEnable;
        end
        else if (expUnderflow)
        begin
            code    = FPXU_CODE_UNDERFLOW;
            capture = ctrl.underflowIrqEnable;
        end

        // registers change only here, both at once; no write path exists
        if (capture)
        begin
            state_next.causeCode = code;
            state_next.instrAddr = instr.addr;
        end
        state_next.errorFlag  = capture;
        state_next.irqReq     = capture && !ctrl.globalIrqDisable;
        state_next.trapVector = FPXU_TRAP_VECTOR;

        // operand addressing
        state_next.addr.isFloat      = isFloat;
        state_next.addr.mode         = specMode;
        state_next.addr.gpr          = specReg;
        state_next.addr.operandIsAcc = (specMode == FPXU_MODE_ACC);
        if (accFieldUsed)
        begin
            state_next.addr.accSelect = {1'b0, accumulator_select};
        end
        else
        begin
            state_next.addr.accSelect = specReg;
        end
        state_next.addr.stepSize = ctrl.doublePrecisionSel
                                   ? FPXU_STEP_DOUBLE : FPXU_STEP_SINGLE;
        state_next.addr.stepUp   = (specMode == FPXU_MODE_AUTOINC)
                                   || (specMode == FPXU_MODE_AUTOINCD);
        state_next.addr.stepDown = (specMode == FPXU_MODE_AUTODEC)
                                   || (specMode == FPXU_MODE_AUTODECD);
        state_next.addr.intWidth32 = ctrl.longIntegerSel;

        // word 0 is the most significant and lies lowest
        state_next.memWordAddr = memBase + {13'h0000, memWordIdx, 1'b0};

        // result shaping
        state_next.result.valid         = isFloat;
        state_next.result.sign          = arith.resSign;
        state_next.result.overflowFlag  = expOverflow;
        state_next.result.underflowFlag = expUnderflow;
        state_next.result.frac          = normFrac[FPXU_XFRAC_W-1:FPXU_GUARD_W];
        state_next.result.exp           = normExp[FPXU_EXP_W-1:0];
        state_next.result.zero          = 1'b0;
        if (operandZero && !arith.isDivide && !badAcc && !undefVar)
        begin
            state_next.result.zero = 1'b1;
        end
        else if (arith.isDivide && (arith.dstExp == '0) && !divZero)
        begin
            state_next.result.zero = 1'b1;
        end
        else if (expUnderflow && !ctrl.underflowIrqEnable)
        begin
            state_next.result.zero = 1'b1;
        end
        else if (expOverflow && !ctrl.overflowIrqEnable)
        begin
            state_next.result.zero = 1'b1;
        end
        if (state_next.result.zero)
        begin
            state_next.result.sign = 1'b0;
            state_next.result.exp  = '0;
            state_next.result.frac = '0;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign exception_cause_code = state_reg.causeCode;
    assign exception_instr_addr = state_reg.instrAddr;
    assign error_flag           = state_reg.errorFlag;
    assign irqReq               = state_reg.irqReq;
    assign trapVector           = state_reg.trapVector;
    assign addrInfo             = state_reg.addr;
    assign memWordAddr          = state_reg.memWordAddr;
    assign result               = state_reg.result;

endmodule

`default_nettype wire

// ===== testbench/fpxu_exception_unit_sva.sv
// assertions on the ports of the floating exception unit
// assumes one clock domain and a bind onto fpxu_exception_unit
`timescale 1ns/1ps
`default_nettype none
module fpxu_exception_unit_sva
(
    // clock and reset
    input wire logic                  ref_clk,
    input wire logic                  resetn,
    // inputs
    input wire fpxu_pkg::fpxu_ctrl_s  ctrl,
    input wire fpxu_pkg::fpxu_instr_s instr,
    input wire fpxu_pkg::fpxu_arith_s arith,
    input wire logic [15:0]           memBase,
    input wire logic [1:0]            memWordIdx,
    // outputs
    input wire logic [3:0]            exception_cause_code,
    input wire logic [15:0]           exception_instr_addr,
    input wire logic                  error_flag,
    input wire logic                  irqReq,
    input wire logic [7:0]            trapVector,
    input wire fpxu_pkg::fpxu_addr_s  addrInfo,
    input wire logic [15:0]           memWordAddr,
    input wire fpxu_pkg::fpxu_result_s result
);
    import fpxu_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    logic isFp;
    assign isFp = instr.valid && instr.word[15:12] == FPXU_MAJOR_OPCODE;

    property p_vector; $past(resetn) |-> trapVector == 8'ha4; endproperty
    a_vector: assert property (p_vector) else $error("trap vector wrong");
    property p_code; error_flag |-> exception_cause_code inside {2, 4, 6, 8, 10, 12}; endproperty
    a_code: assert property (p_code) else $error("cause code illegal");
    property p_addr; error_flag |-> exception_instr_addr == $past(instr.addr); endproperty
    a_addr: assert property (p_addr) else $error("address not captured");
    property p_hold; !error_flag |-> $stable(exception_cause_code) && $stable(exception_instr_addr); endproperty
    a_hold: assert property (p_hold) else $error("registers changed");
    property p_badacc; isFp && instr.word[5:1] == 5'h3 |=> error_flag && exception_cause_code == 4'h2 && irqReq != $past(ctrl.globalIrqDisable); endproperty
    a_badacc: assert property (p_badacc) else $error("accumulator 6 or 7 not trapped");
    property p_irq; irqReq |-> error_flag && !$past(ctrl.globalIrqDisable); endproperty
    a_irq: assert property (p_irq) else $error("trap without capture");
    property p_nonfp; !isFp |=> !error_flag && !result.valid; endproperty
    a_nonfp: assert property (p_nonfp) else $error("non floating word acted on");
    property p_step; isFp |=> addrInfo.stepSize == ($past(ctrl.doublePrecisionSel) ? 4'h8 : 4'h4); endproperty
    a_step: assert property (p_step) else $error("step size wrong");
    property p_mem; 1'b1 |=> memWordAddr == $past(memBase) + {13'h0, $past(memWordIdx), 1'b0}; endproperty
    a_mem: assert property (p_mem) else $error("word address wrong");
    property p_div; isFp && arith.isDivide && arith.srcExp == 8'h0 && arith.dstExp != 8'h0 && instr.word[5:3] != 3'h0 && !ctrl.undefVarIrqEnable |=> error_flag && exception_cause_code == 4'h4; endproperty
    a_div: assert property (p_div) else $error("divide by zero missed");
endmodule
bind fpxu_exception_unit fpxu_exception_unit_sva u_sva (.ref_clk(ref_clk), .resetn(resetn),
    .ctrl(ctrl), .instr(instr), .arith(arith), .memBase(memBase), .memWordIdx(memWordIdx),
    .exception_cause_code(exception_cause_code), .exception_instr_addr(exception_instr_addr),
    .error_flag(error_flag), .irqReq(irqReq), .trapVector(trapVector), .addrInfo(addrInfo),
    .memWordAddr(memWordAddr), .result(result));
`default_nettype wire

// ===== testbench/fpxu_cpu_model.sv
// processor side model presenting one instruction, floating or not, per cycle
// assumes the caller invokes issue just after a falling edge
`timescale 1ns/1ps
`default_nettype none
module fpxu_cpu_model
(
    // to the floating unit
    output var fpxu_pkg::fpxu_ctrl_s  ctrl,
    output var fpxu_pkg::fpxu_instr_s instr,
    output var logic                  accFieldUsed,
    output var fpxu_pkg::fpxu_arith_s arith,
    output var logic [15:0]           memBase,
    output var logic [1:0]            memWordIdx
);
    import fpxu_pkg::*;
    initial
    begin
        ctrl = '0;
        instr = '0;
        accFieldUsed = 1'b0;
        arith = '0;
        memBase = 16'h0;
        memWordIdx = 2'h0;
    end
    // between calls the outputs hold the last value issued
    task automatic issue(input fpxu_ctrl_s c, input fpxu_instr_s i, input fpxu_arith_s a,
                         input logic [15:0] b, input logic [1:0] w);
        ctrl = c;
        instr = i;
        accFieldUsed = i.word[11];
        arith = a;
        memBase = b;
        memWordIdx = w;
    endtask
endmodule
`default_nettype wire

// ===== testbench/fpxu_testbench.sv
// self-checking bench for the floating exception unit
// assumes the cpu model drives all unit inputs but clock and reset
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import fpxu_pkg::*;
    logic ref_clk;
    logic resetn;
    fpxu_ctrl_s ctrl;
    fpxu_instr_s instr;
    logic accFieldUsed;
    fpxu_arith_s arith;
    logic [15:0] memBase;
    logic [1:0] memWordIdx;
    logic [3:0] exception_cause_code;
    logic [15:0] exception_instr_addr;
    logic error_flag;
    logic irqReq;
    logic [7:0] trapVector;
    fpxu_addr_s addrInfo;
    logic [15:0] memWordAddr;
    fpxu_result_s result;
    int failures = 0;
    int checked = 0;
    logic [31:0] seed = 32'h5f;
    logic [3:0] expCode = 4'h0;
    logic [15:0] expAddr = 16'h0;
    logic [3:0] pCode;
    logic pGid, pFloat, pResChk;
    logic [15:0] pMem;
    logic [16:0] pAi;
    logic [64:0] pRes;
    logic [3:0] pFlags;
    logic pSign;

    fpxu_cpu_model cpu (.ctrl(ctrl), .instr(instr), .accFieldUsed(accFieldUsed), .arith(arith),
        .memBase(memBase), .memWordIdx(memWordIdx));
    fpxu_exception_unit DUT (.ref_clk(ref_clk), .resetn(resetn), .ctrl(ctrl), .instr(instr),
        .accFieldUsed(accFieldUsed), .arith(arith), .memBase(memBase), .memWordIdx(memWordIdx),
        .exception_cause_code(exception_cause_code), .exception_instr_addr(exception_instr_addr),
        .error_flag(error_flag), .irqReq(irqReq), .trapVector(trapVector), .addrInfo(addrInfo),
        .memWordAddr(memWordAddr), .result(result));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // cause code by fixed priority, 0 when nothing is captured
    function automatic logic [3:0] exp_code(fpxu_ctrl_s c, fpxu_instr_s i, fpxu_arith_s a);
        if (!i.valid || i.word[15:12] != 4'hf) return 4'h0;
        if (i.word[5:1] == 5'h3) return 4'h2;
        if (c.undefVarIrqEnable && ((a.srcSign && a.srcExp == 8'h0) || (a.dstSign && a.dstExp == 8'h0)))
            return 4'hc;
        if (a.isDivide && a.srcExp == 8'h0) return 4'h4;
        if (a.convFail) return c.convIrqEnable ? 4'h6 : 4'h0;
        if (a.srcExp == 8'h0 || a.dstExp == 8'h0) return 4'h0;
        if (a.resExp[9:8] == 2'h1) return c.overflowIrqEnable ? 4'h8 : 4'h0;
        if (a.resExp[9] || a.resExp == 10'h0) return c.underflowIrqEnable ? 4'ha : 4'h0;
        return 4'h0;
    endfunction
    // result as zero flag, exponent, fraction; single keeps the top 24 bits
    function automatic logic [64:0] exp_res(fpxu_ctrl_s c, fpxu_arith_s a);
        logic [55:0] f;
        logic [23:0] s;
        f = a.resFrac[57:2] + (c.chopSel ? 56'h0 : {55'h0, a.resFrac[1]});
        s = a.resFrac[57:34] + (c.chopSel ? 24'h0 : {23'h0, a.resFrac[33]});
        if (!c.doublePrecisionSel) f = {s, 32'h0};
        if (a.srcExp == 8'h0 || a.dstExp == 8'h0) return {1'b1, 64'h0};
        if (a.resExp[9:8] == 2'h1 && !c.overflowIrqEnable) return {1'b1, 64'h0};
        if ((a.resExp[9] || a.resExp == 10'h0) && !c.underflowIrqEnable) return {1'b1, 64'h0};
        return {1'b0, a.resExp[7:0], f};
    endfunction
    task automatic chk(input logic [64:0] got, input logic [64:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic check_prev();
        chk(exception_cause_code, expCode, "code");
        chk(exception_instr_addr, expAddr, "address");
        chk(error_flag, pCode != 4'h0, "capture");
        chk(irqReq, pCode != 4'h0 && !pGid, "trap");
        chk(memWordAddr, pMem, "word address");
        chk({result.valid, addrInfo.isFloat, result.overflowFlag, result.underflowFlag}, pFlags,
            "flags");
        if (pFloat) chk({addrInfo.mode, addrInfo.gpr, addrInfo.accSelect, addrInfo.operandIsAcc,
            addrInfo.stepSize, addrInfo.stepUp, addrInfo.stepDown, addrInfo.intWidth32}, pAi,
            "decode");
        if (pResChk) chk({result.zero, result.exp, result.frac}, pRes, "result");
        if (pResChk) chk(result.sign, pSign, "sign");
    endtask
    task automatic print_verdict();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    initial
    begin
        #(25 * 3000);
        failures++;
        print_verdict();
    end
    initial
    begin
        fpxu_ctrl_s c;
        fpxu_instr_s i;
        fpxu_arith_s a;
        logic [31:0] r, r2, r3, r4, r5;
        logic [9:0] edgeExp [5] = '{10'h0ff, 10'h100, 10'h001, 10'h3ff, 10'h000};
        resetn = 1'b0;
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
        resetn = 1'b1;
        for (int n = 0; n < 600; n++)
        begin
            @(negedge ref_clk);
            if (n > 0) check_prev();
            r = rnd();
            r2 = rnd();
            r3 = rnd();
            r4 = rnd();
            r5 = rnd();
            c = fpxu_ctrl_s'(r[31:24]);
            i.valid = r[2:0] != 3'h0;
            i.word = {(r[5:3] == 3'h0) ? r[9:6] : 4'hf, r[21:10]};
            i.addr = r2[15:0];
            a.isDivide = r3[0];
            a.srcSign = r3[1];
            a.srcExp = (r3[3:2] == 2'h0) ? 8'h0 : r3[11:4];
            a.dstSign = r3[12];
            a.dstExp = (r3[14:13] == 2'h0) ? 8'h0 : r3[22:15];
            a.resExp = (r3[24:23] == 2'h1) ? {2'h1, r3[31:24]}
                     : {r3[24:23] == 2'h2 ? 2'h3 : 2'h0, r3[31:25], 1'b1};
            a.convFail = r3[24:23] == 2'h3 && r5[31];
            a.resSign = r5[30];
            // bit 56 clear keeps rounding from carrying into the exponent
            a.resFrac = {2'h2, r4, r5[23:0]};
            if (n % 8 == 2) a.resExp = edgeExp[(n / 8) % 5];
            if (n == 1)
            begin
                i = {1'b1, 16'hf006, r2[15:0]};
                c.globalIrqDisable = 1'b1;
            end
            cpu.issue(c, i, a, r2[31:16], r[23:22]);
            pCode = exp_code(c, i, a);
            if (pCode != 4'h0)
            begin
                expCode = pCode;
                expAddr = i.addr;
            end
            pGid = c.globalIrqDisable;
            pMem = r2[31:16] + {13'h0, r[23:22], 1'b0};
            pFloat = i.valid && i.word[15:12] == 4'hf;
            pAi = {i.word[5:0], i.word[11] ? {1'b0, i.word[7:6]} : i.word[2:0],
                   i.word[5:3] == 3'h0, c.doublePrecisionSel ? 4'h8 : 4'h4,
                   i.word[5:4] == 2'h1, i.word[5:4] == 2'h2, c.longIntegerSel};
            pResChk = pFloat && !a.convFail
                      && pCode != 4'h2 && pCode != 4'h4 && pCode != 4'hc;
            pRes = exp_res(c, a);
            pSign = pRes[64] ? 1'b0 : a.resSign;
            pFlags = {pFloat, pFloat,
                      pFloat && a.srcExp != 8'h0 && a.dstExp != 8'h0 && a.resExp[9:8] == 2'h1,
                      pFloat && a.srcExp != 8'h0 && a.dstExp != 8'h0
                      && (a.resExp[9] || a.resExp == 10'h0)};
        end
        @(negedge ref_clk);
        check_prev();
        $display("random test done");
        resetn = 1'b0;
        repeat (2) @(negedge ref_clk);
        chk(exception_cause_code, 4'h0, "reset code");
        chk(exception_instr_addr, 16'h0, "reset address");
        resetn = 1'b1;
        repeat (2) @(negedge ref_clk);
        chk(trapVector, 8'ha4, "vector");
        $display("reset test done");
        print_verdict();
    end
endmodule
`default_nettype wire
